// ---- rtl/crc_seed_pkg.sv ----
// Purpose: Shared constants and types of the DMA CRC seed/feedback block
// Assumes: 32-bit APB register slave, one word per register
// Notes:   Offsets are byte addresses on the APB

package crc_seed_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned LEN_W  = 5;

  // Register byte offsets
  localparam logic [7:0] OFF_SEED_RESULT   = 8'h00;
  localparam logic [7:0] OFF_FEEDBACK_TAPS = 8'h04;

  // Reset values
  localparam logic [31:0] RST_SEED_RESULT   = 32'h00000000;
  localparam logic [31:0] RST_FEEDBACK_TAPS = 32'h00000000;

  // Steps per data word, minus one
  localparam logic [4:0] LFSR_LAST_STEP = 5'h1F;
  localparam logic [4:0] IP_LAST_STEP   = 5'h01;

  // Position of the type select bit in the external control register
  localparam int unsigned CRC_TYPE_BIT = 5;

  typedef enum logic [0:0] {
    PH_IDLE  = 1'b0,
    PH_SHIFT = 1'b1
  } phase_e;

  // Ones on bit positions 0 up to and including the polynomial length
  function automatic logic [31:0] len_mask(input logic [4:0] polynomial_length);
    len_mask = 32'hFFFFFFFF >> (5'h1F - polynomial_length);
  endfunction

endpackage

// ---- rtl/crc_step_if.sv ----
// Purpose: Carries the generator state between the core and its step units
// Assumes: Purely combinational step units
// Notes:   The core drives the operands and reads back both next values

`timescale 1ns/1ns

interface crc_step_if;
  logic [31:0] state;
  logic [31:0] taps;
  logic [4:0]  polynomial_length;
  logic        data_bit;
  logic [15:0] half;
  logic [31:0] lfsr_next;
  logic [15:0] csum_next;

  modport core (output state, taps, polynomial_length, data_bit, half,
                input  lfsr_next, csum_next);
  modport lfsr (input  state, taps, polynomial_length, data_bit,
                output lfsr_next);
  modport csum (input  state, half,
                output csum_next);
endinterface : crc_step_if

// ---- rtl/crc_lfsr_step.sv ----
// Purpose: One bit step of the programmable shift register
// Assumes: Feedback taken from the stage picked by the polynomial length
// Notes:   Result is masked to the active length

`timescale 1ns/1ns

module crc_lfsr_step (
  crc_step_if.lfsr step
);

  logic        feedback;
  logic [31:0] raw_next;

  // Top active stage mixed with the incoming bit
  assign feedback = step.state[step.polynomial_length] ^ step.data_bit;

  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_stage
      if (g == 0) begin : g_first
        // No preceding stage: only the feedback term can enter
        assign raw_next[g] = step.taps[g] & feedback;
      end else begin : g_rest
        // Tap clear: plain shift from the preceding stage
        assign raw_next[g] = step.state[g-1] ^ (step.taps[g] & feedback);
      end
    end
  endgenerate

  assign step.lfsr_next = raw_next & crc_seed_pkg::len_mask(step.polynomial_length);

endmodule // crc_lfsr_step

// ---- rtl/crc_csum_step.sv ----
// Purpose: One halfword step of the ones-complement header checksum
// Assumes: Accumulator holds the uncomplemented sum in its low 16 bits
// Notes:   Feedback taps are not an operand here

`timescale 1ns/1ns

module crc_csum_step (
  crc_step_if.csum step
);

  logic [16:0] wide_sum;

  assign wide_sum = {1'b0, step.state[15:0]} + {1'b0, step.half};

  // End-around carry; cannot overflow a second time
  assign step.csum_next = wide_sum[15:0] + {15'h0000, wide_sum[16]};

endmodule // crc_csum_step

// ---- rtl/dma_crc_seed_and_feedback.sv ----
// Purpose: Seed/result and feedback-tap registers of a DMA CRC generator
// Assumes: Mode and length come from a control register on the same clock
// Notes:   One data word taken at a time; ready drops while it is consumed
//
// Implementation choices: the register addresses and the APB register port.

`timescale 1ns/1ns

module dma_crc_seed_and_feedback (
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [7:0]  i_paddr,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  input  wire logic        i_crc_type_select,
  input  wire logic [4:0]  i_polynomial_length,
  input  wire logic        i_data_valid,
  input  wire logic [31:0] i_data_word,
  output logic             o_data_ready,
  output logic             o_busy
);

  typedef struct packed {
    crc_seed_pkg::phase_e phase;
    logic [31:0]          seed;
    logic [31:0]          taps;
    logic [31:0]          word;
    logic [4:0]           count;
    logic [31:0]          prdata;
    logic                 pslverr;
  } state_s;

  state_s st;
  state_s next_st;

  crc_step_if step ();

  crc_lfsr_step u_lfsr (
    .step (step.lfsr)
  );

  crc_csum_step u_csum (
    .step (step.csum)
  );

  logic        setup;
  logic        access;
  logic        hit_seed;
  logic        hit_taps;
  logic        seed_wr;
  logic        taps_wr;
  logic        accept;
  logic        ip_mode;
  logic [31:0] polynomial_length_mask;
  logic [31:0] seed_view;

  assign ip_mode   = i_crc_type_select;
  assign polynomial_length_mask = crc_seed_pkg::len_mask(i_polynomial_length);
  assign setup     = i_psel & ~i_penable;
  assign access    = i_psel & i_penable;
  assign hit_seed  = (i_paddr == crc_seed_pkg::OFF_SEED_RESULT);
  assign hit_taps  = (i_paddr == crc_seed_pkg::OFF_FEEDBACK_TAPS);
  assign seed_wr   = access & i_pwrite & hit_seed;
  assign taps_wr   = access & i_pwrite & hit_taps;

  // Seed writes take priority over a new data word
  assign accept = i_data_valid & o_data_ready;

  // Software view of the running result
  always_comb begin
    if (ip_mode) begin
      seed_view = {16'h0000, ~st.seed[15:0]};
    end else begin
      seed_view = st.seed & polynomial_length_mask;
    end
  end

  assign step.state    = st.seed;
  assign step.taps     = st.taps;
  assign step.polynomial_length     = i_polynomial_length;
  assign step.data_bit = st.word[31];
  assign step.half     = st.word[31:16];

  always_comb begin
    next_st = st;
    // Read data is captured in the setup cycle so it comes from a flop
    if (setup) begin
      next_st.pslverr = ~(hit_seed | hit_taps);
      if (i_pwrite) begin
        next_st.prdata = 32'h00000000;
      end else if (hit_seed) begin
        next_st.prdata = seed_view;
      end else if (hit_taps) begin
        next_st.prdata = st.taps;
      end else begin
        next_st.prdata = 32'h00000000;
      end
    end
    if (st.phase == crc_seed_pkg::PH_SHIFT) begin
      if (ip_mode) begin
        next_st.seed = {16'h0000, step.csum_next};
        next_st.word = {st.word[15:0], 16'h0000};
      end else begin
        next_st.seed = step.lfsr_next;
        next_st.word = {st.word[30:0], 1'b0};
      end
      if (st.count == 5'h00) begin
        next_st.phase = crc_seed_pkg::PH_IDLE;
      end else begin
        next_st.count = st.count - 5'h01;
      end
    end else if (accept) begin
      next_st.phase = crc_seed_pkg::PH_SHIFT;
      next_st.word  = i_data_word;
      next_st.count = ip_mode ? crc_seed_pkg::IP_LAST_STEP
                              : crc_seed_pkg::LFSR_LAST_STEP;
    end
    if (taps_wr) begin
      next_st.taps = i_pwdata;
    end
    // A new seed restarts the generator and drops any word in flight
    if (seed_wr) begin
      next_st.phase = crc_seed_pkg::PH_IDLE;
      if (ip_mode) begin
        next_st.seed = {16'h0000, ~i_pwdata[15:0]};
      end else begin
        next_st.seed = i_pwdata;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      st.phase   <= crc_seed_pkg::PH_IDLE;
      st.seed    <= crc_seed_pkg::RST_SEED_RESULT;
      st.taps    <= crc_seed_pkg::RST_FEEDBACK_TAPS;
      st.word    <= 32'h00000000;
      st.count   <= 5'h00;
      st.prdata  <= 32'h00000000;
      st.pslverr <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign o_pready     = access;
  assign o_prdata     = st.prdata;
  assign o_pslverr    = st.pslverr & access;
  assign o_busy       = (st.phase == crc_seed_pkg::PH_SHIFT);
  assign o_data_ready = (st.phase == crc_seed_pkg::PH_IDLE) & ~seed_wr;

  // Checks

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);

  logic [31:0] shifted_plain;
  logic        top_feedback;
  logic [16:0] ip_wide;
  logic [15:0] ip_fold;

  assign shifted_plain = {st.seed[30:0], 1'b0} & polynomial_length_mask;
  assign top_feedback  = st.seed[i_polynomial_length] ^ st.word[31];
  // Reference fold kept apart from the step unit so a tap leak would show
  assign ip_wide = {1'b0, st.seed[15:0]} + {1'b0, st.word[31:16]};
  assign ip_fold = ip_wide[15:0] + {15'h0000, ip_wide[16]};

  a_seed_write_load: assert property (
    seed_wr && !ip_mode |=> st.seed == $past(i_pwdata)
  ) else $error("seed write did not load the generator");

  a_read_returns_result: assert property (
    setup && !i_pwrite && hit_seed && !ip_mode
    |=> access && o_prdata == ($past(st.seed) & $past(polynomial_length_mask))
  ) else $error("seed read did not return the running result");

  a_lfsr_upper_zero: assert property (
    o_pready && !i_pwrite && hit_seed && !ip_mode
    && $stable(i_polynomial_length)
    |-> (o_prdata & ~polynomial_length_mask) == 32'h00000000
  ) else $error("result bits above the length not zero");

  a_type_picks_mode: assert property (
    accept && !seed_wr
    |=> st.count == ($past(ip_mode) ? crc_seed_pkg::IP_LAST_STEP
                                    : crc_seed_pkg::LFSR_LAST_STEP)
  ) else $error("step count does not match the selected mode");

  a_ip_upper_zero: assert property (
    o_pready && !i_pwrite && hit_seed && ip_mode && $past(ip_mode)
    |-> o_prdata[31:16] == 16'h0000
  ) else $error("checksum upper half not zero");

  a_ip_write_complement: assert property (
    seed_wr && ip_mode
    |=> st.seed == {16'h0000, ~$past(i_pwdata[15:0])}
  ) else $error("checksum write not stored in complement form");

  a_ip_read_complement: assert property (
    setup && !i_pwrite && hit_seed && ip_mode
    |=> o_prdata == {16'h0000, ~$past(st.seed[15:0])}
  ) else $error("checksum read not in complement form");

  a_taps_read_back: assert property (
    setup && !i_pwrite && hit_taps
    |=> o_prdata == $past(st.taps)
  ) else $error("tap register read did not return its value");

  a_ready_while_busy: assert property (
    o_busy |-> !o_data_ready
  ) else $error("data ready raised while a word is consumed");

  a_tap_feedback: assert property (
    o_busy && !ip_mode && !seed_wr
    |=> st.seed == ($past(shifted_plain)
                    ^ ($past(st.taps) & $past(polynomial_length_mask)
                       & {32{$past(top_feedback)}}))
  ) else $error("tap feedback not applied to enabled stages");

  a_tap_clear_shift: assert property (
    o_busy && !ip_mode && !seed_wr && st.taps == 32'h00000000
    |=> st.seed == $past(shifted_plain)
  ) else $error("stage without tap did not copy its neighbour");

  a_ip_ignores_taps: assert property (
    o_busy && ip_mode && !seed_wr
    |=> st.seed == {16'h0000, $past(ip_fold)}
        && st.seed[31:16] == 16'h0000
  ) else $error("checksum step disturbed by taps");

  a_bit_per_step: assert property (
    accept && !ip_mode && !seed_wr ##1 (!seed_wr)[*8]
    |-> o_busy && st.count == 5'h18
  ) else $error("shift register did not advance once per bit");

  a_word_length: assert property (
    o_busy && st.count == 5'h00 && !seed_wr |=> !o_busy && o_data_ready
  ) else $error("word did not finish after its last step");

  c_lfsr_word: cover property (
    accept && !ip_mode ##1 (o_busy && !seed_wr)[*8]
  );

  c_ip_word: cover property (
    accept && ip_mode ##3 !o_busy
  );

  c_seed_read: cover property (
    o_pready && !i_pwrite && hit_seed && o_busy
  );

  c_write_abort: cover property (
    o_busy && seed_wr
  );

endmodule // dma_crc_seed_and_feedback

// ---- testbench/dma_word_source.sv ----
// Purpose: DMA channel data path that offers words to the CRC block
// Assumes: A word is held with valid until taken at a rising edge
// Notes:   A released data line shows the inverse of the last word

`timescale 1ns/1ns

module dma_word_source (
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_send,
  input  wire logic [31:0] i_word,
  input  wire logic        i_ready,
  output logic             o_valid,
  output logic [31:0]      o_word
);
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_valid <= 1'b0;
      o_word  <= 32'h00000000;
    end else if (o_valid && i_ready) begin
      o_valid <= 1'b0;
      // Stale data must not look like a fresh word
      o_word  <= ~o_word;
    end else if (i_send && !o_valid) begin
      o_valid <= 1'b1;
      o_word  <= i_word;
    end
  end
endmodule // dma_word_source

// ---- testbench/tb_dma_crc_seed_and_feedback.sv ----
// Purpose: Self-checking bench of the DMA CRC seed/feedback block
// Assumes: Zero-wait APB slave, seed at 0x00 and taps at 0x04
// Notes:   Expected results come from bench reference functions

`timescale 1ns/1ns

module tb_dma_crc_seed_and_feedback;
  logic        i_core_clk = 1'b0;
  logic        i_sys_rst  = 1'b1;
  logic [7:0]  i_paddr    = 8'h00;
  logic        i_psel     = 1'b0;
  logic        i_penable  = 1'b0;
  logic        i_pwrite   = 1'b0;
  logic [31:0] i_pwdata   = 32'h00000000;
  logic        i_crc_type_select   = 1'b0;
  logic [4:0]  i_polynomial_length = 5'h1F;
  logic        send = 1'b0;
  logic [31:0] word = 32'h00000000;
  logic        o_pready, o_pslverr, dvalid, dready, o_busy, sl;
  logic [31:0] o_prdata, dword, rd, sd, tp, wd;
  logic [31:0] rng = 32'h00000036;
  logic [4:0]  pl;
  int          err_total = 0;
  int          num_checks = 0;

  dma_crc_seed_and_feedback dma_crc_seed_and_feedback_i (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_paddr(i_paddr),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_pslverr(o_pslverr), .i_crc_type_select(i_crc_type_select),
    .i_polynomial_length(i_polynomial_length), .i_data_valid(dvalid),
    .i_data_word(dword), .o_data_ready(dready), .o_busy(o_busy));

  dma_word_source dma_word_source_i (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_send(send),
    .i_word(word), .i_ready(dready), .o_valid(dvalid), .o_word(dword));

  always #20 i_core_clk = ~i_core_clk;

  function logic [31:0] rnd();
    for (int k = 0; k < 32; k++)
      rng = {rng[30:0], rng[31] ^ rng[21] ^ rng[1] ^ rng[0]};
    return rng;
  endfunction

  function automatic logic [31:0] mask(input logic [4:0] p);
    return 32'hFFFFFFFF >> (5'h1F - p);
  endfunction

  function automatic logic [31:0] lfsr_exp(input logic [31:0] s, t, w,
                                           input logic [4:0] p);
    logic fb;
    s = s & mask(p);
    for (int b = 31; b >= 0; b--) begin
      fb = s[p] ^ w[b];
      s = ((s << 1) ^ (t & {32{fb}})) & mask(p);
    end
    return s;
  endfunction

  // Adds upper then lower half with end-around carry
  function automatic logic [31:0] csum_exp(input logic [15:0] a,
                                           input logic [31:0] w);
    logic [16:0] x;
    x = a + w[31:16];
    a = x[15:0] + x[16];
    x = a + w[15:0];
    a = x[15:0] + x[16];
    return {16'h0000, ~a};
  endfunction

  task automatic results();
    if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge i_core_clk);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_paddr   <= a;
    i_pwrite  <= wr;
    i_pwdata  <= d;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      results();
    end
    rd = o_prdata;
    sl = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask

  // With cyc zero the word is left in flight for the caller to disturb
  task automatic push(input logic [31:0] w, input int cyc);
    int n, b;
    @(posedge i_core_clk);
    send <= 1'b1;
    word <= w;
    @(posedge i_core_clk);
    send <= 1'b0;
    if (cyc == 0) return;
    n = 0;
    b = 0;
    do begin
      @(posedge i_core_clk);
      n++;
      if (o_busy === 1'b1) b++;
      if (o_busy === 1'b1) check("ready low", {31'h0, dready}, 32'h0);
    end while ((dvalid !== 1'b0 || o_busy !== 1'b0) && n < 80);
    if (n >= 80) begin
      err_total++;
      results();
    end
    check("busy cycles", b, cyc);
  endtask

  initial begin
    repeat (16) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    apb(1'b0, 8'h00, 32'h00000000);
    check("seed reset", rd, 32'h00000000);
    apb(1'b0, 8'h04, 32'h00000000);
    check("taps reset", rd, 32'h00000000);
    apb(1'b1, 8'h08, rnd());
    check("unmapped error", {31'h0, sl}, 32'h00000001);
    for (int i = 0; i < 24; i++) begin
      sd = rnd();
      wd = rnd();
      tp = (i == 2) ? 32'h00000000 : rnd();
      pl = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : sd[4:0];
      i_polynomial_length <= pl;
      apb(1'b1, 8'h04, tp);
      apb(1'b0, 8'h04, 32'h00000000);
      check("taps", rd, tp);
      apb(1'b1, 8'h00, sd);
      apb(1'b0, 8'h00, 32'h00000000);
      check("seed masked", rd, sd & mask(pl));
      push(wd, 32);
      apb(1'b0, 8'h00, 32'h00000000);
      check("lfsr", rd, lfsr_exp(sd, tp, wd, pl));
    end
    i_crc_type_select <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      sd = rnd();
      wd = rnd();
      apb(1'b1, 8'h00, sd);
      apb(1'b0, 8'h00, 32'h00000000);
      check("csum seed", rd, {16'h0000, sd[15:0]});
      apb(1'b1, 8'h04, rnd());
      push(wd, 2);
      apb(1'b0, 8'h00, 32'h00000000);
      check("csum", rd, csum_exp(~sd[15:0], wd));
    end
    // Shift mode so the word is still in flight when the seed lands
    i_crc_type_select   <= 1'b0;
    i_polynomial_length <= 5'h0F;
    push(rnd(), 0);
    repeat (6) @(posedge i_core_clk);
    apb(1'b0, 8'h00, 32'h00000000);
    check("mid busy", {31'h0, o_busy}, 32'h00000001);
    check("mid upper", rd & ~mask(5'h0F), 32'h00000000);
    apb(1'b1, 8'h00, 32'h00001234);
    apb(1'b0, 8'h00, 32'h00000000);
    check("abort seed", rd, 32'h00001234);
    check("abort idle", {31'h0, o_busy}, 32'h00000000);
    results();
  end
endmodule // tb_dma_crc_seed_and_feedback
